/* File: bit_branch_unit.sv */
// Bit processor and program flow execution unit
module bit_branch_unit (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Instruction from fetch path
    input wire logic start_i,
    input wire bpu_pkg::instr_s instr_i,
    output logic ready_o,
    output logic [1:0] instr_len_o,
    // Context and bit read data
    input wire bpu_pkg::ctx_s ctx_i,
    input wire logic bit_rd_i,
    // Bit space access
    output bpu_pkg::bit_s bit_o,
    // Results
    output logic done_o,
    output bpu_pkg::res_s res_o
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_r;
    wire logic rst_n = rst_sync_r[1];

    // Release is delayed two clocks; assertion is immediate
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // ****************************************
    // Decode functions
    // ****************************************
    // Machine cycles taken by each operation
    function automatic logic two_mc(input bpu_pkg::op_e op);
        unique case (op)
            bpu_pkg::copy_c_bit, bpu_pkg::clear_c, bpu_pkg::clear_bit,
            bpu_pkg::set_c, bpu_pkg::set_bit, bpu_pkg::cpl_c,
            bpu_pkg::cpl_bit, bpu_pkg::no_operation:
                two_mc = 1'b0;
            default: two_mc = 1'b1;
        endcase
    endfunction

    // Whether the operation reads or writes an addressed bit
    function automatic logic uses_bit(input bpu_pkg::op_e op);
        unique case (op)
            bpu_pkg::and_c_bit, bpu_pkg::and_c_nbit, bpu_pkg::or_c_bit,
            bpu_pkg::or_c_nbit, bpu_pkg::copy_c_bit, bpu_pkg::copy_bit_c,
            bpu_pkg::clear_bit, bpu_pkg::set_bit, bpu_pkg::cpl_bit,
            bpu_pkg::branch_bit_one, bpu_pkg::branch_bit_zero,
            bpu_pkg::branch_bit_and_clear:
                uses_bit = 1'b1;
            default: uses_bit = 1'b0;
        endcase
    endfunction

    // Offset byte sits in the third byte for bit and compare branches
    function automatic logic rel_in_b2(input bpu_pkg::instr_s ins);
        unique case (ins.op)
            bpu_pkg::branch_bit_one, bpu_pkg::branch_bit_zero,
            bpu_pkg::branch_bit_and_clear, bpu_pkg::compare_branch_unequal:
                rel_in_b2 = 1'b1;
            bpu_pkg::decrement_branch_nonzero: rel_in_b2 = ins.decrement_branch_nonzero_dir;
            default: rel_in_b2 = 1'b0;
        endcase
    endfunction

    // ****************************************
    // Sequencer state
    // ****************************************
    typedef enum logic {st_idle, st_exec} state_e;
    state_e state_r;
    bpu_pkg::instr_s ins_r;     // Latched instruction
    logic [3:0] clk_cnt_r;      // Clock within machine cycle
    logic mc_idx_r;             // Machine cycle index
    logic done_r;
    bpu_pkg::res_s res_r;
    logic bit_wr_r;
    logic bit_wdata_r;

    // Last clock of the last machine cycle
    wire logic last_clk = (state_r == st_exec) && (clk_cnt_r == bpu_pkg::MC_LAST)
        && (mc_idx_r == two_mc(ins_r.op));
    wire logic take = (state_r == st_idle) && start_i;

    assign ready_o = (state_r == st_idle);

    // Instruction length of the presented instruction
    assign instr_len_o =
        (instr_i.op == bpu_pkg::long_absolute_jump) ? 2'd3 :
        (instr_i.op == bpu_pkg::long_subroutine_call) ? 2'd3 :
        (instr_i.op == bpu_pkg::short_relative_jump) ? 2'd2 :
        (instr_i.op == bpu_pkg::page_absolute_jump) ? 2'd2 :
        (instr_i.op == bpu_pkg::page_subroutine_call) ? 2'd2 :
        rel_in_b2(instr_i) ? 2'd3 :
        (uses_bit(instr_i.op) || instr_i.op == bpu_pkg::branch_carry_one
         || instr_i.op == bpu_pkg::branch_carry_zero
         || instr_i.op == bpu_pkg::branch_acc_zero
         || instr_i.op == bpu_pkg::branch_acc_nonzero
         || instr_i.op == bpu_pkg::decrement_branch_nonzero) ? 2'd2 : 2'd1;

    // ****************************************
    // Bit space mapping
    // ****************************************
    wire logic [7:0] baddr = ins_r.b1;
    wire logic in_sfr = baddr[bpu_pkg::BIT_SPACE_MSB];
    // RAM bits fill sixteen bytes, eight per byte
    wire logic [7:0] ram_byte = 8'(bpu_pkg::RAM_BIT_BASE + {4'h0, baddr[6:3]});
    // Register bits live in bytes whose low three address bits are zero
    wire logic [7:0] sfr_byte = {baddr[7:3], 3'b000};

    assign bit_o.byte_addr = in_sfr ? sfr_byte : ram_byte;
    assign bit_o.idx = baddr[2:0];
    assign bit_o.special_function_register_space = in_sfr;
    assign bit_o.wr = bit_wr_r;
    assign bit_o.wdata = bit_wdata_r;

    // ****************************************
    // Execution decisions
    // ****************************************
    wire bpu_pkg::op_e op = ins_r.op;
    wire logic cy = ctx_i.carry;
    wire logic [7:0] dec_val = 8'(ctx_i.opnd_a - 8'h01);
    wire logic cmp_less = ctx_i.opnd_a < ctx_i.opnd_b;
    wire logic cmp_ne = ctx_i.opnd_a != ctx_i.opnd_b;
    wire logic acc_zero = ctx_i.acc == 8'h00;

    // Branch condition for conditional operations
    wire logic cond =
        (op == bpu_pkg::branch_carry_one) ? cy :
        (op == bpu_pkg::branch_carry_zero) ? !cy :
        (op == bpu_pkg::branch_bit_one) ? bit_rd_i :
        (op == bpu_pkg::branch_bit_zero) ? !bit_rd_i :
        (op == bpu_pkg::branch_bit_and_clear) ? bit_rd_i :
        (op == bpu_pkg::branch_acc_zero) ? acc_zero :
        (op == bpu_pkg::branch_acc_nonzero) ? !acc_zero :
        (op == bpu_pkg::decrement_branch_nonzero) ? (dec_val != 8'h00) :
        (op == bpu_pkg::compare_branch_unequal) ? cmp_ne : 1'b0;

    // Unconditional flow changes
    wire logic is_call = (op == bpu_pkg::long_subroutine_call)
        || (op == bpu_pkg::page_subroutine_call);
    wire logic is_ret = (op == bpu_pkg::subroutine_exit) || (op == bpu_pkg::interrupt_exit);
    wire logic uncond = is_call || is_ret || (op == bpu_pkg::short_relative_jump)
        || (op == bpu_pkg::long_absolute_jump) || (op == bpu_pkg::page_absolute_jump)
        || (op == bpu_pkg::generic_jump_ind);

    // Target selection
    wire bpu_pkg::tgt_e tsel =
        (op == bpu_pkg::long_absolute_jump || op == bpu_pkg::long_subroutine_call)
            ? bpu_pkg::tgt_long :
        (op == bpu_pkg::page_absolute_jump || op == bpu_pkg::page_subroutine_call)
            ? bpu_pkg::tgt_page :
        (op == bpu_pkg::generic_jump_ind) ? bpu_pkg::tgt_ind :
        is_ret ? bpu_pkg::tgt_ret : bpu_pkg::tgt_rel;
    wire logic [7:0] rel_byte = rel_in_b2(ins_r) ? ins_r.b2 : ins_r.b1;
    logic [15:0] target;

    pc_target_calc u_target (
        .sel_i(tsel),
        .next_pc_i(ins_r.next_pc),
        .rel_i(rel_byte),
        .opc_i(ins_r.opc),
        .lo_i(ins_r.b1),
        .hi_i(ins_r.b2),
        .acc_i(ctx_i.acc),
        .data_pointer_i(ctx_i.data_pointer),
        .ret_i(ctx_i.ret_addr),
        .target_o(target)
    );

    // Carry update; no exclusive-OR form exists on single bits
    wire logic cy_wr = (op == bpu_pkg::and_c_bit) || (op == bpu_pkg::and_c_nbit)
        || (op == bpu_pkg::or_c_bit) || (op == bpu_pkg::or_c_nbit)
        || (op == bpu_pkg::copy_c_bit) || (op == bpu_pkg::clear_c)
        || (op == bpu_pkg::set_c) || (op == bpu_pkg::cpl_c)
        || (op == bpu_pkg::compare_branch_unequal);
    wire logic cy_val =
        (op == bpu_pkg::and_c_bit) ? (cy & bit_rd_i) :
        (op == bpu_pkg::and_c_nbit) ? (cy & !bit_rd_i) :
        (op == bpu_pkg::or_c_bit) ? (cy | bit_rd_i) :
        (op == bpu_pkg::or_c_nbit) ? (cy | !bit_rd_i) :
        (op == bpu_pkg::copy_c_bit) ? bit_rd_i :
        (op == bpu_pkg::set_c) ? 1'b1 :
        (op == bpu_pkg::cpl_c) ? !cy :
        (op == bpu_pkg::compare_branch_unequal) ? cmp_less : 1'b0;

    // Addressed bit update
    wire logic bw = (op == bpu_pkg::copy_bit_c) || (op == bpu_pkg::clear_bit)
        || (op == bpu_pkg::set_bit) || (op == bpu_pkg::cpl_bit)
        || ((op == bpu_pkg::branch_bit_and_clear) && bit_rd_i);
    wire logic bw_val =
        (op == bpu_pkg::copy_bit_c) ? cy :
        (op == bpu_pkg::set_bit) ? 1'b1 :
        (op == bpu_pkg::cpl_bit) ? !bit_rd_i : 1'b0;

    // ****************************************
    // Sequencer
    // ****************************************
    // Counts twelve clocks per machine cycle, then reports
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= st_idle;
            clk_cnt_r <= 4'h0;
            mc_idx_r <= 1'b0;
            ins_r <= '0;
        end else if (clk_en_i) begin
            if (take) begin
                state_r <= st_exec;
                ins_r <= instr_i;
                clk_cnt_r <= 4'h0;
                mc_idx_r <= 1'b0;
            end else if (last_clk) begin
                state_r <= st_idle;
            end else if (state_r == st_exec) begin
                // Wrap the clock count at the end of the first of two machine cycles
                if (clk_cnt_r == bpu_pkg::MC_LAST) begin
                    clk_cnt_r <= 4'h0;
                    mc_idx_r <= 1'b1;
                end else begin
                    clk_cnt_r <= 4'(clk_cnt_r + 4'h1);
                end
            end
        end
    end

    // ****************************************
    // Result registers
    // ****************************************
    // Strobes last one clock; values are sampled at the final clock
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b0;
            res_r <= '0;
            bit_wr_r <= 1'b0;
            bit_wdata_r <= 1'b0;
        end else if (clk_en_i) begin
            done_r <= last_clk;
            bit_wr_r <= last_clk && bw;
            bit_wdata_r <= bw_val;
            res_r <= '0;
            if (last_clk) begin
                res_r.pc_load <= uncond || cond;
                res_r.pc <= target;
                res_r.carry_wr <= cy_wr;
                res_r.carry <= cy_val;
                res_r.byte_wr <= (op == bpu_pkg::decrement_branch_nonzero);
                res_r.byte_val <= dec_val;
                res_r.push <= is_call;
                res_r.push_addr <= ins_r.next_pc;
                res_r.irq_done <= (op == bpu_pkg::interrupt_exit)
                    && ctx_i.irq_active;
            end
        end
    end

    assign done_o = done_r;
    assign res_o = res_r;

    // ****************************************
    // Checks
    // ****************************************
    // Enabled clocks since the taking edge; zero at that edge so the
    // count seen with done equals the clocks the instruction spent
    logic [5:0] run_cnt_r;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt_r <= 6'h00;
        end else if (clk_en_i) begin
            run_cnt_r <= take ? 6'h00 : 6'(run_cnt_r + 6'h01);
        end
    end

    a_cycle_count: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        $rose(done_r) |-> run_cnt_r == (two_mc(ins_r.op) ? bpu_pkg::CNT_W2
            : bpu_pkg::CNT_W1))
        else $error("execution length wrong");

    a_bit_map_ram: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !baddr[bpu_pkg::BIT_SPACE_MSB] |-> !bit_o.special_function_register_space
            && bit_o.byte_addr == 8'(bpu_pkg::RAM_BIT_BASE + baddr[6:3]))
        else $error("RAM bit mapped wrong");

    a_bit_map_sfr: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        baddr[bpu_pkg::BIT_SPACE_MSB] |-> bit_o.special_function_register_space && bit_o.byte_addr[2:0] == 3'b000)
        else $error("register bit mapped wrong");

    a_rel_target: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        done_r && res_r.pc_load && ins_r.op == bpu_pkg::short_relative_jump
        |-> res_r.pc == 16'(ins_r.next_pc + {{8{ins_r.b1[7]}}, ins_r.b1}))
        else $error("relative target wrong");

    a_page_high_kept: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        done_r && ins_r.op == bpu_pkg::page_absolute_jump
        |-> res_r.pc[15:11] == ins_r.next_pc[15:11] && res_r.pc[7:0] == ins_r.b1)
        else $error("page target wrong");

    a_clear_on_take: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        done_r && ins_r.op == bpu_pkg::branch_bit_and_clear
        |-> res_r.pc_load == bit_o.wr && (!bit_o.wr || !bit_o.wdata))
        else $error("test-and-clear wrong");

    a_compare_carry: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        done_r && ins_r.op == bpu_pkg::compare_branch_unequal
        |-> res_r.carry_wr && res_r.carry == $past(cmp_less)
            && res_r.pc_load == $past(cmp_ne))
        else $error("compare result wrong");

    a_acc_zero_test: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        done_r && ins_r.op == bpu_pkg::branch_acc_zero
        |-> res_r.pc_load == ($past(ctx_i.acc) == 8'h00))
        else $error("zero branch wrong");

    a_plain_return: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        done_r && ins_r.op == bpu_pkg::subroutine_exit |-> !res_r.irq_done
            && res_r.pc_load)
        else $error("plain return flagged interrupt");

    a_call_pushes: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        done_r && ins_r.op == bpu_pkg::long_subroutine_call
        |-> res_r.push && res_r.push_addr == ins_r.next_pc
            && res_r.pc == {ins_r.b2, ins_r.b1})
        else $error("call push wrong");

endmodule

/* File: bit_space_model.sv */
// Behavioural bit space behind the bit branch unit
module bit_space_model (
    // Clock
    input wire logic core_clk_i,
    // Bit access from the unit
    input wire bpu_pkg::bit_s bit_i,
    // Read data
    output logic bit_rd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // One flag per byte and index; cleared so no read is unknown
    logic [2047:0] mem_r = '0;
    // Read follows the selected place at once
    assign bit_rd_o = mem_r[{bit_i.byte_addr, bit_i.idx}];
    // Store on the write pulse; the unit supplies the new bit value itself
    always @(posedge core_clk_i) begin
        if (bit_i.wr === 1'b1) begin
            mem_r[{bit_i.byte_addr, bit_i.idx}] <= bit_i.wdata;
        end
    end
    // Preset a flag from the bench
    task automatic put(input logic [10:0] a, input logic v);
        mem_r[a] = v;
    endtask
endmodule

/* File: bpu_pkg.sv */
// Shared constants and types for the bit processor and branch unit
package bpu_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int MC_CLKS = 12;                   // Core clocks per machine cycle
    localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);
    localparam logic [5:0] CNT_W1 = 6'h0C;         // Clocks in one machine cycle
    localparam logic [5:0] CNT_W2 = 6'h18;         // Clocks in two machine cycles

    // ****************************************
    // Bit space and address fields
    // ****************************************
    localparam int BIT_SPACE_MSB = 7;              // Set selects register space
    localparam logic [7:0] RAM_BIT_BASE = 8'h20;   // First byte of bit RAM
    localparam int OPC_PAGE_LSB = 5;               // Page bits sit in opcode [7:5]
    localparam int PAGE_W = 11;                    // Bits replaced by a page jump

    // Operations as handed over by the fetch path
    typedef enum logic [4:0] {
        and_c_bit, and_c_nbit, or_c_bit, or_c_nbit,
        copy_c_bit, copy_bit_c, clear_c, clear_bit,
        set_c, set_bit, cpl_c, cpl_bit,
        branch_carry_one, branch_carry_zero, branch_bit_one,
        branch_bit_zero, branch_bit_and_clear,
        short_relative_jump, long_absolute_jump, page_absolute_jump,
        generic_jump_ind, long_subroutine_call, page_subroutine_call,
        subroutine_exit, interrupt_exit, no_operation,
        branch_acc_zero, branch_acc_nonzero,
        decrement_branch_nonzero, compare_branch_unequal
    } op_e;

    // Target selection for the program counter calculator
    typedef enum logic [2:0] {tgt_rel, tgt_page, tgt_long, tgt_ind, tgt_ret} tgt_e;

    // One instruction from the fetch path
    typedef struct packed {
        op_e op;
        logic [7:0] opc;        // Opcode byte
        logic [7:0] b1;         // Second byte
        logic [7:0] b2;         // Third byte
        logic [15:0] next_pc;   // Address of byte after the instruction
        logic decrement_branch_nonzero_dir;         // Decrement form with direct byte
    } instr_s;

    // Core context sampled at execution
    typedef struct packed {
        logic [7:0] acc;
        logic [15:0] data_pointer;
        logic carry;
        logic [7:0] opnd_a;     // First operand byte
        logic [7:0] opnd_b;     // Second operand byte
        logic [15:0] ret_addr;  // Address popped from the stack
        logic irq_active;       // Interrupt in progress
    } ctx_s;

    // Bit space access
    typedef struct packed {
        logic [7:0] byte_addr;
        logic [2:0] idx;
        logic special_function_register_space;
        logic wr;
        logic wdata;
    } bit_s;

    // Execution results, valid with done
    typedef struct packed {
        logic pc_load;
        logic [15:0] pc;
        logic carry_wr;
        logic carry;
        logic byte_wr;
        logic [7:0] byte_val;
        logic push;
        logic [15:0] push_addr;
        logic irq_done;
    } res_s;

endpackage

/* File: pc_target_calc.sv */
// Program counter target calculator for jumps, calls and returns
module pc_target_calc (
    // Selection and sources
    input wire bpu_pkg::tgt_e sel_i,
    input wire logic [15:0] next_pc_i,
    input wire logic [7:0] rel_i,
    input wire logic [7:0] opc_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] hi_i,
    input wire logic [7:0] acc_i,
    input wire logic [15:0] data_pointer_i,
    input wire logic [15:0] ret_i,
    // Result
    output logic [15:0] target_o
);

    // ****************************************
    // Candidate targets
    // ****************************************
    // Sign extension of the offset byte
    wire logic [15:0] rel_ext = {{8{rel_i[7]}}, rel_i};
    // Sums wrap at 16 bits; no overflow is reported
    wire logic [15:0] rel_tgt = 16'(next_pc_i + rel_ext);
    // Upper bits kept, low eleven from opcode and byte
    wire logic [15:0] page_tgt = {next_pc_i[15:bpu_pkg::PAGE_W],
        opc_i[7:bpu_pkg::OPC_PAGE_LSB], lo_i};
    wire logic [15:0] long_tgt = {hi_i, lo_i};
    // Computed continuously; selected only for the indirect jump
    wire logic [15:0] ind_tgt = 16'(data_pointer_i + {8'h00, acc_i});

    // ****************************************
    // Selection
    // ****************************************
    always_comb begin
        unique case (sel_i)
            bpu_pkg::tgt_rel: target_o = rel_tgt;
            bpu_pkg::tgt_page: target_o = page_tgt;
            bpu_pkg::tgt_long: target_o = long_tgt;
            bpu_pkg::tgt_ind: target_o = ind_tgt;
            bpu_pkg::tgt_ret: target_o = ret_i;
            default: target_o = next_pc_i;
        endcase
    end

endmodule

/* File: testbench.sv */
// Self-checking bench for the bit processor and branch unit
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Signals
    // ****************************************
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic clk_en = 1'b1; // Lowered only by the freeze scenario
    int frozen = 0; // Disabled clocks expected inside one instruction
    bpu_pkg::instr_s instr = '0;
    bpu_pkg::ctx_s ctx = '0;
    logic ready;
    logic [1:0] instr_len;
    logic bit_rd;
    bpu_pkg::bit_s bit_acc;
    logic done;
    bpu_pkg::res_s res;
    bpu_pkg::res_s got; // Results seen with done
    logic [1:0] wr; // Write pulse and data seen with done
    int err_count = 0;
    int compares = 0;
    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;
    bit_branch_unit u_bit_branch_unit (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .clk_en_i(clk_en), .start_i(start), .instr_i(instr), .ready_o(ready),
        .instr_len_o(instr_len), .ctx_i(ctx), .bit_rd_i(bit_rd), .bit_o(bit_acc),
        .done_o(done), .res_o(res));
    bit_space_model u_bit_space_model (.core_clk_i(core_clk), .bit_i(bit_acc),
        .bit_rd_o(bit_rd));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One instruction; the instruction stays driven so its length can be read after
    task automatic exec(input bpu_pkg::op_e op, input logic [7:0] opc, input logic [7:0] b1,
            input logic [7:0] b2, input logic [15:0] npc, input logic dj, input int mc);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        instr = '{op, opc, b1, b2, npc, dj};
        start = 1'b1;
        check(32'(ready), 32'h1);
        @(posedge core_clk);
        #1;
        start = 1'b0;
        check(32'(ready), 32'h0);
        // Bounded wait; a hang counts as a mismatch
        while (done !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 400) begin
            err_count++;
            stop_test();
        end
        got = res;
        wr = {bit_acc.wr, bit_acc.wdata};
        check(n, bpu_pkg::MC_CLKS * mc + frozen);
    endtask
    // Carry logic, bit stores and bit space mapping
    task automatic bit_ops();
        u_bit_space_model.put(11'h113, 1'b0);
        ctx.carry = 1'b1;
        exec(bpu_pkg::and_c_bit, 8'h82, 8'h13, 8'h00, 16'h0102, 1'b0, 2);
        check({bit_acc.byte_addr, bit_acc.idx, bit_acc.special_function_register_space}, {8'h22, 3'h3, 1'b0});
        check({got.carry_wr, got.carry}, 2'b10);
        ctx.carry = 1'b0;
        exec(bpu_pkg::or_c_nbit, 8'hA0, 8'h13, 8'h00, 16'h0102, 1'b0, 2);
        check({got.carry_wr, got.carry}, 2'b11);
        exec(bpu_pkg::set_bit, 8'hD2, 8'h85, 8'h00, 16'h0102, 1'b0, 1);
        check({bit_acc.byte_addr, bit_acc.idx, bit_acc.special_function_register_space}, {8'h80, 3'h5, 1'b1});
        check(wr, 2'b11);
        exec(bpu_pkg::copy_c_bit, 8'hA2, 8'h85, 8'h00, 16'h0102, 1'b0, 1);
        check({got.carry_wr, got.carry}, 2'b11);
        ctx.carry = 1'b1;
        exec(bpu_pkg::copy_bit_c, 8'h92, 8'h13, 8'h00, 16'h0102, 1'b0, 2);
        check(wr, 2'b11);
        exec(bpu_pkg::cpl_c, 8'hB3, 8'h00, 8'h00, 16'h0101, 1'b0, 1);
        check({got.carry_wr, got.carry}, 2'b10);
    endtask
    // Carry and bit branches, negative offset wrapping below zero
    task automatic bit_branches();
        exec(bpu_pkg::branch_carry_one, 8'h40, 8'h80, 8'h00, 16'h0010, 1'b0, 2);
        check({got.pc_load, got.pc}, {1'b1, 16'hFF90});
        exec(bpu_pkg::branch_carry_zero, 8'h50, 8'h7F, 8'h00, 16'h0010, 1'b0, 2);
        check(got.pc_load, 1'b0);
        exec(bpu_pkg::branch_bit_and_clear, 8'h10, 8'h13, 8'h05, 16'h0200, 1'b0, 2);
        check({got.pc_load, got.pc, wr}, {1'b1, 16'h0205, 2'b10});
        exec(bpu_pkg::branch_bit_one, 8'h20, 8'h13, 8'h05, 16'h0200, 1'b0, 2);
        check(got.pc_load, 1'b0);
        exec(bpu_pkg::branch_bit_zero, 8'h30, 8'h13, 8'h05, 16'h0200, 1'b0, 2);
        check({instr_len, got.pc_load, got.pc}, {2'h3, 1'b1, 16'h0205});
    endtask
    // Unconditional flow changes, all two machine cycles, then a one-cycle no-operation
    task automatic jumps();
        exec(bpu_pkg::short_relative_jump, 8'h80, 8'h7F, 8'h00, 16'h1000, 1'b0, 2);
        check({instr_len, got.pc_load, got.pc}, {2'h2, 1'b1, 16'h107F});
        exec(bpu_pkg::long_absolute_jump, 8'h02, 8'h34, 8'hAB, 16'h0003, 1'b0, 2);
        check({instr_len, got.pc}, {2'h3, 16'hAB34});
        exec(bpu_pkg::page_absolute_jump, 8'hE1, 8'h34, 8'h00, 16'hF7FE, 1'b0, 2);
        check(got.pc, 16'hF734);
        ctx.data_pointer = 16'hFFF0;
        ctx.acc = 8'h20;
        exec(bpu_pkg::generic_jump_ind, 8'h73, 8'h00, 8'h00, 16'h0100, 1'b0, 2);
        check(got.pc, 16'h0010);
        exec(bpu_pkg::long_subroutine_call, 8'h12, 8'h78, 8'h56, 16'h3003, 1'b0, 2);
        check({got.pc, got.push, got.push_addr}, {16'h5678, 1'b1, 16'h3003});
        exec(bpu_pkg::page_subroutine_call, 8'h31, 8'hFF, 8'h00, 16'h2802, 1'b0, 2);
        check({got.pc, got.push, got.push_addr}, {16'h29FF, 1'b1, 16'h2802});
        ctx.ret_addr = 16'h2802;
        ctx.irq_active = 1'b1;
        exec(bpu_pkg::subroutine_exit, 8'h22, 8'h00, 8'h00, 16'h0501, 1'b0, 2);
        check({got.pc_load, got.pc, got.irq_done}, {1'b1, 16'h2802, 1'b0});
        exec(bpu_pkg::interrupt_exit, 8'h32, 8'h00, 8'h00, 16'h0501, 1'b0, 2);
        check({got.pc_load, got.pc, got.irq_done}, {1'b1, 16'h2802, 1'b1});
        ctx.irq_active = 1'b0;
        exec(bpu_pkg::interrupt_exit, 8'h32, 8'h00, 8'h00, 16'h0501, 1'b0, 2);
        check({got.pc_load, got.irq_done}, 2'b10);
        exec(bpu_pkg::no_operation, 8'h00, 8'h00, 8'h00, 16'h0501, 1'b0, 1);
        check(got.pc_load, 1'b0);
    endtask
    // Accumulator tests, loop decrement and compare
    task automatic cond_jumps();
        logic [7:0] a [3] = '{8'h03, 8'h05, 8'h09};
        ctx.acc = 8'h00;
        exec(bpu_pkg::branch_acc_zero, 8'h60, 8'h10, 8'h00, 16'h0400, 1'b0, 2);
        check({got.pc_load, got.pc}, {1'b1, 16'h0410});
        exec(bpu_pkg::branch_acc_nonzero, 8'h70, 8'h10, 8'h00, 16'h0400, 1'b0, 2);
        check(got.pc_load, 1'b0);
        ctx.opnd_a = 8'h01;
        exec(bpu_pkg::decrement_branch_nonzero, 8'hD5, 8'h30, 8'hF0, 16'h0500, 1'b1, 2);
        check({instr_len, got.byte_wr, got.byte_val, got.pc_load}, {2'h3, 9'h100, 1'b0});
        ctx.opnd_a = 8'h00;
        exec(bpu_pkg::decrement_branch_nonzero, 8'hD8, 8'hF0, 8'h00, 16'h0500, 1'b0, 2);
        check({instr_len, got.byte_val, got.pc_load, got.pc}, {2'h2, 8'hFF, 1'b1, 16'h04F0});
        ctx.opnd_b = 8'h05;
        for (int i = 0; i < 3; i++) begin
            ctx.opnd_a = a[i];
            exec(bpu_pkg::compare_branch_unequal, 8'hB4, 8'h05, 8'h08, 16'h0600, 1'b0, 2);
            check({got.pc_load, got.carry}, {1'(i != 1), 1'(i == 0)});
        end
    endtask
    // Enable low for five clocks mid-instruction; done must come five clocks late
    task automatic freeze();
        frozen = 5;
        fork
            begin
                repeat (4) @(posedge core_clk);
                #1;
                clk_en = 1'b0;
                repeat (5) @(posedge core_clk);
                #1;
                clk_en = 1'b1;
            end
        join_none
        exec(bpu_pkg::no_operation, 8'h00, 8'h00, 8'h00, 16'h0501, 1'b0, 1);
        frozen = 0;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        bit_ops();
        bit_branches();
        jumps();
        cond_jumps();
        freeze();
        stop_test();
    end
endmodule
